/* core/assp_port.sv */
// Serial shift port: pin sampling, shift chain, frame buffer, channel decode
//
// Function
// - Capture data bit on each serial clock rise.
// - Shift only while active-low frame enable low.
// - Latch received word, update selected channel attenuation.
// - Far-end bit leaves on serial output each shift.
// - Addresses 0,1,2 select channels; others ignored.
// - Half, one, two dB step bands.
// - Mute at power-up and codes 4F upward.
`timescale 1ns/10ps
`default_nettype none
module assp_port (
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // Serial pins from the host or upstream device
  input  wire logic        ser_clk,
  input  wire logic        frame_n,
  input  wire logic        ser_din,
  // Serial output to the next device in the chain
  output logic             ser_dout,
  // Frame buffer has room for a command
  output logic             frame_ready,
  // Attenuator ladder accepts a new setting
  input  wire logic        upd_ready,
  // Per-channel settings in half-dB units, plus mute
  output logic [2:0][7:0]  ch_half_db,
  output logic [2:0]       ch_mute
);
  logic [2:0]  clk_sync;   // Serial clock synchroniser
  logic [2:0]  frm_sync;   // Frame enable synchroniser
  logic [2:0]  din_sync;   // Data synchroniser
  logic        clk_rise;   // Qualified serial clock edge
  logic        frm_rise;   // Frame close
  logic        frm_low;    // Frame open
  logic        shift;      // Take one bit this cycle
  logic [15:0] sreg;       // Shift chain
  logic        fifo_ready; // Room in buffer
  logic        cmd_valid;  // Buffered command ready
  logic [15:0] cmd_word;   // Buffered command
  logic        apply;      // Command applied this cycle
  logic [7:0]  cmd_addr;   // Address byte
  logic [7:0]  cmd_code;   // Code byte

  ////////////////////////////////////////////////////////////////////////////
  // Code to half-dB mapping; used by the update path only
  function automatic logic [7:0] code_to_half_db(input logic [7:0] code);
    logic [9:0] wide;
    wide = {2'b00, code};
    if (code <= assp_pkg::CODE_FINE_MAX) begin
      code_to_half_db = code;
    end else if (code <= assp_pkg::CODE_MID_MAX) begin
      wide = (wide << 1) - assp_pkg::MID_OFFSET;
      code_to_half_db = wide[7:0];
    end else begin
      wide = (wide << 2) - assp_pkg::COARSE_OFFSET;
      code_to_half_db = wide[7:0];
    end
  endfunction

  // Address to channel index, NUM_CH when unknown
  function automatic logic [1:0] addr_to_ch(input logic [7:0] addr);
    case (addr)
      assp_pkg::ADDR_CH1: addr_to_ch = 2'd0;
      assp_pkg::ADDR_CH2: addr_to_ch = 2'd1;
      assp_pkg::ADDR_CH3: addr_to_ch = 2'd2;
      default:            addr_to_ch = 2'(assp_pkg::NUM_CH);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Three-flop synchronisers; edges judged on stages two and three only
  // Pin levels must last one core cycle or an edge is lost
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clk_sync <= '0;
      frm_sync <= '1; // Idle high so no frame close at release
      din_sync <= '0;
    end else if (clk_en) begin
      clk_sync <= {clk_sync[1:0], ser_clk};
      frm_sync <= {frm_sync[1:0], frame_n};
      din_sync <= {din_sync[1:0], ser_din};
    end
  end

  // Edge detection; data stage three lines up with clock stage
  assign clk_rise = clk_sync[1] && !clk_sync[2];
  assign frm_rise = frm_sync[1] && !frm_sync[2];
  assign frm_low  = !frm_sync[2];
  // Clock edges while frame enable is high are dropped
  assign shift    = clk_en && clk_rise && frm_low;

  ////////////////////////////////////////////////////////////////////////////
  // Shift chain, MSB arrives first and ends at the top
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sreg <= assp_pkg::SREG_RESET;
    end else if (shift) begin
      sreg <= {sreg[assp_pkg::FRAME_BITS-2:0], din_sync[2]};
    end
  end

  // Far end drives the chain output; changes a few cycles after the
  // serial edge, so the next device still samples the old bit
  assign ser_dout = sreg[assp_pkg::FRAME_BITS-1];

  ////////////////////////////////////////////////////////////////////////////
  // Frame close pushes the last sixteen bits; a full buffer drops the
  // frame, so the host should watch frame_ready between frames
  assp_fifo #(
    .WIDTH (assp_pkg::FRAME_BITS),
    .DEPTH (assp_pkg::FIFO_DEPTH),
    .AW    (assp_pkg::FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .in_valid  (frm_rise),
    .in_ready  (fifo_ready),
    .in_data   (sreg),
    .out_valid (cmd_valid),
    .out_ready (upd_ready),
    .out_data  (cmd_word)
  );
  assign frame_ready = fifo_ready;

  // Command fields
  assign cmd_addr = cmd_word[assp_pkg::ADDR_MSB:assp_pkg::ADDR_LSB];
  assign cmd_code = cmd_word[assp_pkg::CODE_MSB:assp_pkg::CODE_LSB];
  assign apply    = clk_en && cmd_valid && upd_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Channel settings; muted from power-up until a valid command
  // One command touches one channel; the others keep their setting
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ch_half_db <= {assp_pkg::NUM_CH{assp_pkg::HALF_DB_RESET}};
      ch_mute    <= '1;
    end else if (apply) begin
      for (int i = 0; i < assp_pkg::NUM_CH; i++) begin
        // Unknown address matches no index and changes nothing
        if (addr_to_ch(cmd_addr) == i[1:0]) begin
          ch_mute[i] <= (cmd_code >= assp_pkg::CODE_MUTE_MIN);
          // Level held while muted so unmute is a plain new command
          if (cmd_code < assp_pkg::CODE_MUTE_MIN) begin
            ch_half_db[i] <= code_to_half_db(cmd_code);
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // All checks sleep in reset; the bench covers the power-up state
  sequence frame_close_s;
    clk_en && frm_rise && fifo_ready;
  endsequence

  sequence cmd_taken_s;
    ##[1:2] (apply && addr_to_ch(cmd_addr) == 2'd0);
  endsequence

  shift_capture_a: assert property (@(posedge core_clk) disable iff (!nrst)
    shift |=> sreg == {$past(sreg[14:0]), $past(din_sync[2])})
    else $error("Shift chain did not take the data bit");

  frame_gate_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_rise && !frm_low) |=> $stable(sreg))
    else $error("Shift chain moved outside a frame");

  chain_out_a: assert property (@(posedge core_clk) disable iff (!nrst)
    shift |=> ser_dout == $past(sreg[14]))
    else $error("Chain output did not follow the far end");

  frame_push_a: assert property (@(posedge core_clk) disable iff (!nrst)
    frame_close_s |=> cmd_valid)
    else $error("Closed frame did not reach the buffer");

  apply_ch1_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (frame_close_s ##0 (!cmd_valid && upd_ready && sreg[15:8] == assp_pkg::ADDR_CH1))
    |-> cmd_taken_s)
    else $error("Channel one command was not applied");

  bad_addr_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (apply && addr_to_ch(cmd_addr) == 2'(assp_pkg::NUM_CH))
    |=> $stable(ch_half_db) && $stable(ch_mute))
    else $error("Unknown address changed a setting");

  mid_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (apply && cmd_addr == assp_pkg::ADDR_CH2 && cmd_code == assp_pkg::CODE_MID_MIN)
    |=> ch_half_db[1] == assp_pkg::CODE_MID_MIN && !ch_mute[1])
    else $error("Sixteen dB code gave the wrong level");

  mute_code_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (apply && cmd_addr == assp_pkg::ADDR_CH3 && cmd_code >= assp_pkg::CODE_MUTE_MIN)
    |=> ch_mute[2] && $stable(ch_half_db[2]))
    else $error("Mute code did not mute channel three");

  unmute_ch3_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (apply && cmd_addr == assp_pkg::ADDR_CH3 && cmd_code < assp_pkg::CODE_MUTE_MIN)
    |=> !ch_mute[2])
    else $error("Level code did not unmute channel three");

  // Fine band level equals the code in half-dB units
  fine_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (apply && cmd_addr == assp_pkg::ADDR_CH1 && cmd_code <= assp_pkg::CODE_FINE_MAX)
    |=> ch_half_db[0] == $past(cmd_code) && !ch_mute[0])
    else $error("Half dB code gave the wrong level");

  dout_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !shift |=> $stable(ser_dout))
    else $error("Chain output moved without a shift");

  // A low enable must hold every register, pins are simply missed
  clk_freeze_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !clk_en |=> $stable(sreg) && $stable(ch_half_db) && $stable(ch_mute))
    else $error("State moved while the clock enable was low");
endmodule
`default_nettype wire

/* core/assp_pkg.sv */
// Shared constants for the attenuator serial shift port
package assp_pkg;
  // Frame layout
  localparam int          FRAME_BITS   = 16;
  localparam int          BYTE_BITS    = 8;
  localparam int          ADDR_MSB     = 15;
  localparam int          ADDR_LSB     = 8;
  localparam int          CODE_MSB     = 7;
  localparam int          CODE_LSB     = 0;
  localparam int          NUM_CH       = 3;
  // Channel address codes
  localparam logic [7:0]  ADDR_CH1     = 8'h00;
  localparam logic [7:0]  ADDR_CH2     = 8'h01;
  localparam logic [7:0]  ADDR_CH3     = 8'h02;
  // Attenuation code bands
  localparam logic [7:0]  CODE_FINE_MAX = 8'h1F;
  localparam logic [7:0]  CODE_MID_MIN  = 8'h20;
  localparam logic [7:0]  CODE_MID_MAX  = 8'h3F;
  localparam logic [7:0]  CODE_MUTE_MIN = 8'h4F;
  // Offsets for band arithmetic, in half-dB units
  localparam logic [9:0]  MID_OFFSET    = 10'h020;
  localparam logic [9:0]  COARSE_OFFSET = 10'h0A0;
  // Reset values
  localparam logic [7:0]  HALF_DB_RESET = 8'h00;
  localparam logic [15:0] SREG_RESET    = 16'h0000;
  // Buffering
  localparam int          FIFO_DEPTH    = 16;
  localparam int          FIFO_AW       = 4;
endpackage

/* core/assp_fifo.sv */
// Frame buffer between the serial shifter and the channel update logic
`timescale 1ns/10ps
`default_nettype none
module assp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem [DEPTH]; // Flop storage
  logic [AW:0]      wr_ptr;      // Extra bit tells full from empty
  logic [AW:0]      rd_ptr;      // Read pointer
  logic             push;        // Accepted write
  logic             pop;         // Accepted read

  ////////////////////////////////////////////////////////////////////////////
  // Status, honest full and empty from the pointers
  assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign push      = clk_en && in_valid && in_ready;
  assign pop       = clk_en && out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Storage write, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Write pointer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* verif/assp_host_model.sv */
// Host model that drives the three serial pins of the port
`timescale 1ns/10ps
`default_nettype none
module assp_host_model (
  // System clock, used only to pace the pins
  input  wire logic core_clk,
  // Serial pins toward the device
  output logic      ser_clk,
  output logic      frame_n,
  output logic      ser_din,
  // Chain output from the device
  input  wire logic ser_dout
);
  // Idle: link clock parked low, frame closed
  initial begin
    ser_clk = 1'b0;
    frame_n = 1'b1;
    ser_din = 1'b0;
  end
  // Pins change only at falling edges
  task automatic gap(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Sends n bits of w; ens high keeps the frame closed and the clocks must be ignored
  task automatic send(input logic [31:0] w, input int n, input logic ens,
                      output logic [31:0] dout);
    dout = '0;
    frame_n = ens; // Low opens the frame
    gap(4);
    for (int i = n - 1; i >= 0; i--) begin
      ser_din = w[i]; // Most significant bit first
      gap(3);
      dout = {dout[30:0], ser_dout}; // Chain bit before this rise
      ser_clk = 1'b1;
      gap(4);
      ser_clk = 1'b0;
      ser_din = ~w[i]; // Hold over: stale value would hide sampling slips
      gap(1);
    end
    gap(4);
    frame_n = 1'b1; // Closed only after every bit is
    gap(6);
  endtask
endmodule
`default_nettype wire

/* verif/attenuator_serial_shift_port_tb.sv */
// Self-checking bench for the attenuator serial shift port
`timescale 1ns/10ps
`default_nettype none
module attenuator_serial_shift_port_tb;
  logic            core_clk;    // System clock
  logic            nrst;        // Async reset
  logic            upd_ready;   // Ladder stall
  logic            clk_en;      // Clock enable
  logic            ser_clk;     // Link pins
  logic            frame_n;
  logic            ser_din;
  logic            ser_dout;
  logic            frame_ready; // Buffer has room
  logic [2:0][7:0] ch_half_db;  // Levels
  logic [2:0]      ch_mute;     // Mutes
  logic [26:0]     exp_q[$];    // Expected {levels, mutes}, oldest first
  logic [26:0]     model;       // Bench view of the settings
  logic [26:0]     seen;        // Last output state seen
  logic [31:0]     dout;        // Bits shifted out during a frame
  logic [15:0]     prev;        // Word held in the chain
  int              miscompares;
  int              tests_run;
  localparam logic [7:0] CODES [9] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'h3F,
                                       8'h40, 8'h4E, 8'h4F, 8'hFF};
  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  assp_port i_dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .ser_clk(ser_clk),
    .frame_n(frame_n), .ser_din(ser_din), .ser_dout(ser_dout), .frame_ready(frame_ready),
    .upd_ready(upd_ready), .ch_half_db(ch_half_db), .ch_mute(ch_mute));
  assp_host_model i_host (.core_clk(core_clk), .ser_clk(ser_clk), .frame_n(frame_n),
    .ser_din(ser_din), .ser_dout(ser_dout));
  ////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input logic [26:0] got, input logic [26:0] want, input string what);
    tests_run++;
    if (got !== want) begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Expected settings after one command
  function automatic logic [26:0] apply(input logic [26:0] s, input logic [7:0] a,
                                        input logic [7:0] c);
    logic [26:0] r;
    r = s;
    if (a <= 8'h02) begin // Only three addresses select
      if (c >= 8'h4F) r[a] = 1'b1; // Mute band, level kept
      else begin
        r[a] = 1'b0;
        r[3 + 8 * a +: 8] = (c <= 8'h1F) ? c : (c <= 8'h3F) ? 8'(2 * c - 32)
                          : 8'(4 * c - 160); // Three step bands
      end
    end
    return r;
  endfunction
  // One frame of n bits; keep low means the buffer will drop it
  task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic keep, input int n);
    logic [26:0] nxt;
    nxt = apply(model, a, c);
    if (keep && nxt !== model) exp_q.push_back(nxt);
    if (keep) model = nxt;
    i_host.send({8'h00, 8'hA5, a, c}, n, 1'b0, dout);
    check({11'h0, dout[n-1 -: 16]}, {11'h0, prev}, "chain out");
    prev = {a, c};
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Monitor: every output change consumes the oldest expectation
  always @(negedge core_clk) begin
    if (nrst === 1'b1 && {ch_half_db, ch_mute} !== seen) begin
      seen = {ch_half_db, ch_mute};
      if (exp_q.size() == 0) check(seen, ~seen, "unexpected update");
      else check(seen, exp_q.pop_front(), "setting");
    end
  end
  // Watchdog, about three times the expected run
  initial begin
    #(400_000);
    check(27'h0, 27'h1, "timeout");
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    upd_ready = 1'b1;
    clk_en = 1'b1;
    prev = 16'h0000;
    model = 27'h7;
    seen = 27'h7;
    miscompares = 0;
    tests_run = 0;
    void'($urandom(32'h2b3c));
    repeat (16) @(negedge core_clk);
    check({ch_half_db, ch_mute}, 27'h7, "power-up mute");
    check({25'h0, ser_dout, frame_ready}, 27'h1, "reset pins");
    nrst = 1'b1;
    foreach (CODES[i]) for (int a = 0; a < 3; a++) frame(8'(a), CODES[i], 1'b1, 16);
    for (int a = 0; a < 3; a++) frame(8'(a), 8'($urandom_range(0, 255)), 1'b1, 16);
    $display("code bands done");
    frame(8'h03, 8'h10, 1'b1, 16);
    frame(8'hFF, 8'h00, 1'b1, 16);
    i_host.send(32'h0000FFFF, 16, 1'b1, dout); // Clocks with frame closed
    frame(8'h01, 8'h05, 1'b1, 16);
    frame(8'h02, 8'h22, 1'b1, 24); // Last sixteen bits count
    $display("address and framing done");
    clk_en = 1'b0;
    i_host.send({16'h0000, 8'h01, 8'h4F}, 16, 1'b0, dout); // Frozen: chain and setting kept
    clk_en = 1'b1;
    $display("clock enable freeze done");
    upd_ready = 1'b0;
    for (int i = 1; i <= 16; i++) frame(8'h00, 8'(i), 1'b1, 16);
    check({26'h0, frame_ready}, 27'h0, "buffer full");
    frame(8'h00, 8'h30, 1'b0, 16); // Dropped while full
    upd_ready = 1'b1;
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(negedge core_clk);
    check({26'h0, frame_ready}, 27'h1, "buffer drained");
    check(27'(exp_q.size()), 27'h0, "all updates seen");
    $display("buffer fill and drain done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
